// file: src/cdc_timing_map.svh
// register offsets, field positions and timing figures of the measurement timing block
// assumes an 8-bit register port addressed by byte
`ifndef CDC_TIMING_MAP_SVH
`define CDC_TIMING_MAP_SVH
`define OFS_CONV_PERIOD_0 8'h09
`define OFS_CONV_PERIOD_1 8'h0A
`define OFS_CONV_PERIOD_2 8'h0B
`define OFS_DISCHARGE_LOW 8'h0C
`define OFS_TRIG_DISCHARGE_HIGH 8'h0D
`define OFS_PRECHARGE_LOW 8'h0E
`define OFS_WARMUP_PRECHARGE_HIGH 8'h0F
`define OFS_FULLCHARGE_LOW 8'h10
`define OFS_REFCAP_FULLCHARGE_HIGH 8'h11
`define OFS_GUARD_CONTROL 8'h12
`define OFS_CLOCK_SELECT 8'h13
`define CLOCK_SOURCE_BIT 0
`define PERIOD_MSB 22
`define PHASE_OFF 10'h3FF
`define START_PIN_MSB 7
`define START_PIN_LSB 6
`define TRIG_MODE_MSB 4
`define TRIG_MODE_LSB 2
`define WARMUP_MSB 5
`define WARMUP_LSB 2
`define REFCAP_MSB 6
`define REFCAP_LSB 2
`define GUARD_PULSED_BIT 7
`define GUARD_EXTERNAL_BIT 6
`define GUARD_EN_MSB 5
`define REG_RESET 8'h00
`define SYNC_INPUTS 6
`define REF_CLK_HZ 25000000
`endif

// file: src/cdc_timing_pkg.sv
// types of the measurement timing block
// assumes cdc_timing_map.svh holds the numbers
package cdc_timing_pkg;
    typedef enum logic [2:0] {
        TRIG_CONTINUOUS = 3'h0,
        TRIG_READ = 3'h1,
        TRIG_TIMER = 3'h2,
        TRIG_TIMER_STRETCHED = 3'h3,
        TRIG_UNDEFINED = 3'h4,
        TRIG_PIN = 3'h5,
        TRIG_COMMAND = 3'h6,
        TRIG_CONTINUOUS_ALT = 3'h7
    } trigger_mode_t;
    typedef enum logic [3:0] {
        PH_IDLE = 4'b0001,
        PH_PRECHARGE = 4'b0010,
        PH_FULLCHARGE = 4'b0100,
        PH_DISCHARGE = 4'b1000
    } phase_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic write;
        logic read;
    } reg_req_t;
    typedef struct packed {
        logic guardAmpSleep;
        logic guardAmpExternal;
        logic [5:0] guardEnable;
        logic [4:0] refCapCode;
    } guard_cfg_t;
endpackage

// file: src/cdc_measurement_timing_config.sv
// measurement cycle sequencer and its configuration registers
// assumes oscillator ticks and gp pins arrive asynchronous, register port on ref_clk
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "cdc_timing_map.svh"
module cdc_measurement_timing_config (
    input wire logic ref_clk,
    input wire logic rst,
    input wire cdc_timing_pkg::reg_req_t regReq,
    output logic [7:0] regRdData,
    input wire logic lowFreqOsc,
    input wire logic highFreqOsc,
    input wire logic [3:0] gpPinIn,
    input wire logic resultRead,
    input wire logic commandStart,
    output logic gpPin3Out,
    output logic gpPin3OutEnN,
    output logic prechargeActive,
    output logic fullchargeActive,
    output logic dischargeActive,
    output logic resultValid,
    output logic sequenceDone,
    output cdc_timing_pkg::guard_cfg_t guardCfg
);
    // ********************************************************
    // registers
    // ********************************************************
    logic [22:0] convPeriod_reg;
    logic [9:0] dischargeTime_reg;
    logic [9:0] prechargeTime_reg;
    logic [9:0] fullchargeTime_reg;
    logic [7:0] trigHigh_reg;
    logic [7:0] warmupHigh_reg;
    logic [7:0] refcapHigh_reg;
    logic [7:0] guardCtrl_reg;
    logic cycleSource_reg;
    logic [7:0] rdData_next;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            convPeriod_reg <= 23'h000000;
            dischargeTime_reg <= 10'h000;
            prechargeTime_reg <= 10'h000;
            fullchargeTime_reg <= 10'h000;
            trigHigh_reg <= `REG_RESET;
            warmupHigh_reg <= `REG_RESET;
            refcapHigh_reg <= `REG_RESET;
            guardCtrl_reg <= `REG_RESET;
            cycleSource_reg <= 1'b0;
        end else if (regReq.write) begin
            case (regReq.addr)
                `OFS_CONV_PERIOD_0: convPeriod_reg[7:0] <= regReq.wrData;
                `OFS_CONV_PERIOD_1: convPeriod_reg[15:8] <= regReq.wrData;
                `OFS_CONV_PERIOD_2: convPeriod_reg[22:16] <= regReq.wrData[6:0];
                `OFS_DISCHARGE_LOW: dischargeTime_reg[7:0] <= regReq.wrData;
                `OFS_TRIG_DISCHARGE_HIGH: begin
                    trigHigh_reg <= regReq.wrData;
                    dischargeTime_reg[9:8] <= regReq.wrData[1:0];
                end
                `OFS_PRECHARGE_LOW: prechargeTime_reg[7:0] <= regReq.wrData;
                `OFS_WARMUP_PRECHARGE_HIGH: begin
                    warmupHigh_reg <= regReq.wrData;
                    prechargeTime_reg[9:8] <= regReq.wrData[1:0];
                end
                `OFS_FULLCHARGE_LOW: fullchargeTime_reg[7:0] <= regReq.wrData;
                `OFS_REFCAP_FULLCHARGE_HIGH: begin
                    refcapHigh_reg <= regReq.wrData;
                    fullchargeTime_reg[9:8] <= regReq.wrData[1:0];
                end
                `OFS_GUARD_CONTROL: guardCtrl_reg <= regReq.wrData;
                `OFS_CLOCK_SELECT: cycleSource_reg <= regReq.wrData[`CLOCK_SOURCE_BIT];
                default: begin
                end
            endcase
        end
    end

    cdc_timing_pkg::trigger_mode_t trigMode;
    logic [1:0] startPinSel;
    logic [3:0] warmupCount;
    assign trigMode = cdc_timing_pkg::trigger_mode_t'(trigHigh_reg[`TRIG_MODE_MSB:`TRIG_MODE_LSB]);
    assign startPinSel = trigHigh_reg[`START_PIN_MSB:`START_PIN_LSB];
    assign warmupCount = warmupHigh_reg[`WARMUP_MSB:`WARMUP_LSB];

    always_comb begin
        rdData_next = 8'h00;
        case (regReq.addr)
            `OFS_CONV_PERIOD_0: rdData_next = convPeriod_reg[7:0];
            `OFS_CONV_PERIOD_1: rdData_next = convPeriod_reg[15:8];
            `OFS_CONV_PERIOD_2: rdData_next = {1'b0, convPeriod_reg[22:16]};
            `OFS_DISCHARGE_LOW: rdData_next = dischargeTime_reg[7:0];
            `OFS_TRIG_DISCHARGE_HIGH: rdData_next = {trigHigh_reg[7:2], dischargeTime_reg[9:8]};
            `OFS_PRECHARGE_LOW: rdData_next = prechargeTime_reg[7:0];
            `OFS_WARMUP_PRECHARGE_HIGH: rdData_next = {warmupHigh_reg[7:2], prechargeTime_reg[9:8]};
            `OFS_FULLCHARGE_LOW: rdData_next = fullchargeTime_reg[7:0];
            `OFS_REFCAP_FULLCHARGE_HIGH: rdData_next = {refcapHigh_reg[7:2], fullchargeTime_reg[9:8]};
            `OFS_GUARD_CONTROL: rdData_next = guardCtrl_reg;
            `OFS_CLOCK_SELECT: rdData_next = {7'h00, cycleSource_reg};
            default: rdData_next = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            regRdData <= 8'h00;
        end else if (regReq.read) begin
            regRdData <= rdData_next;
        end else begin
            regRdData <= 8'h00;
        end
    end

    // ********************************************************
    // input synchronisers: three flops, change taken when 2nd and 3rd agree
    // ********************************************************
    logic [`SYNC_INPUTS-1:0] rawIn;
    logic [`SYNC_INPUTS-1:0] syncRise;
    assign rawIn = {gpPinIn, highFreqOsc, lowFreqOsc};

    genvar gi;
    generate
        for (gi = 0; gi < `SYNC_INPUTS; gi = gi + 1) begin : g_sync
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic lvl_reg;
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                    lvl_reg <= 1'b0;
                end else begin
                    s1_reg <= rawIn[gi];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        lvl_reg <= s3_reg;
                    end
                end
            end
            assign syncRise[gi] = (s2_reg == s3_reg) && s3_reg && !lvl_reg;
        end
    endgenerate

    logic lfTick;
    logic cycleTick;
    assign lfTick = syncRise[0];
    assign cycleTick = cycleSource_reg ? syncRise[1] : syncRise[0];

    // ********************************************************
    // trigger sources
    // ********************************************************
    logic [23:0] timerCnt_reg;
    logic timerFire;
    logic pinFire;
    logic trigEvent;
    logic trigPending_reg;
    logic startMeas;

    // a period of 2*field low-oscillator ticks; field 0 fires every tick
    assign timerFire = lfTick && (timerCnt_reg == 24'h000000);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            timerCnt_reg <= 24'h000000;
        end else if (lfTick) begin
            if (timerCnt_reg == 24'h000000) begin
                timerCnt_reg <= (convPeriod_reg == 23'h000000) ? 24'h000000
                    : ({convPeriod_reg, 1'b0} - 24'h000001);
            end else begin
                timerCnt_reg <= timerCnt_reg - 24'h000001;
            end
        end
    end

    assign pinFire = syncRise[2 + startPinSel];

    always_comb begin
        case (trigMode)
            cdc_timing_pkg::TRIG_READ: trigEvent = resultRead;
            cdc_timing_pkg::TRIG_TIMER: trigEvent = timerFire;
            cdc_timing_pkg::TRIG_TIMER_STRETCHED: trigEvent = timerFire;
            cdc_timing_pkg::TRIG_PIN: trigEvent = pinFire;
            cdc_timing_pkg::TRIG_COMMAND: trigEvent = commandStart;
            default: trigEvent = 1'b0;
        endcase
    end

    // ********************************************************
    // phase sequencer
    // ********************************************************
    cdc_timing_pkg::phase_t phase_reg;
    logic [10:0] phaseCnt_reg;
    logic [3:0] measIdx_reg;
    logic inSequence_reg;
    logic [10:0] preLen;
    logic [10:0] fullLen;
    logic [10:0] disLen;
    logic preOn;
    logic disOn;
    logic continuous;
    logic phaseEnd;
    logic measEnd;
    logic lastMeas;

    assign continuous = (trigMode == cdc_timing_pkg::TRIG_CONTINUOUS)
        || (trigMode == cdc_timing_pkg::TRIG_CONTINUOUS_ALT);
    assign preOn = (prechargeTime_reg != `PHASE_OFF);
    assign disOn = (dischargeTime_reg != `PHASE_OFF) && (cycleSource_reg
        ? (dischargeTime_reg != 10'h000) : 1'b1);
    assign preLen = {1'b0, prechargeTime_reg}
        + ((cycleSource_reg && (fullchargeTime_reg == `PHASE_OFF)) ? 11'h002 : 11'h001);
    assign fullLen = {1'b0, fullchargeTime_reg} + (cycleSource_reg ? 11'h002 : 11'h001);
    assign disLen = {1'b0, dischargeTime_reg} + (cycleSource_reg ? 11'h000 : 11'h001);
    assign phaseEnd = cycleTick && (phaseCnt_reg == 11'h001);
    assign lastMeas = (measIdx_reg == warmupCount);
    assign measEnd = phaseEnd && (phase_reg == cdc_timing_pkg::PH_DISCHARGE)
        || phaseEnd && (phase_reg == cdc_timing_pkg::PH_FULLCHARGE) && !disOn;
    // a further measurement of a running stretched or continuous sequence needs no trigger
    assign startMeas = (phase_reg == cdc_timing_pkg::PH_IDLE)
        && (trigPending_reg || continuous || inSequence_reg);

    // a trigger in the cycle that consumes the previous one is kept
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            trigPending_reg <= 1'b0;
        end else if (trigEvent) begin
            trigPending_reg <= 1'b1;
        end else if (startMeas && !inSequence_reg) begin
            trigPending_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            phase_reg <= cdc_timing_pkg::PH_IDLE;
            phaseCnt_reg <= 11'h000;
        end else begin
            case (phase_reg)
                cdc_timing_pkg::PH_IDLE: begin
                    if (startMeas) begin
                        phase_reg <= preOn ? cdc_timing_pkg::PH_PRECHARGE
                            : cdc_timing_pkg::PH_FULLCHARGE;
                        phaseCnt_reg <= preOn ? preLen : fullLen;
                    end
                end
                cdc_timing_pkg::PH_PRECHARGE: begin
                    if (phaseEnd) begin
                        phase_reg <= cdc_timing_pkg::PH_FULLCHARGE;
                        phaseCnt_reg <= fullLen;
                    end else if (cycleTick) begin
                        phaseCnt_reg <= phaseCnt_reg - 11'h001;
                    end
                end
                cdc_timing_pkg::PH_FULLCHARGE: begin
                    if (phaseEnd) begin
                        phase_reg <= disOn ? cdc_timing_pkg::PH_DISCHARGE
                            : cdc_timing_pkg::PH_IDLE;
                        phaseCnt_reg <= disOn ? disLen : 11'h000;
                    end else if (cycleTick) begin
                        phaseCnt_reg <= phaseCnt_reg - 11'h001;
                    end
                end
                cdc_timing_pkg::PH_DISCHARGE: begin
                    if (phaseEnd) begin
                        phase_reg <= cdc_timing_pkg::PH_IDLE;
                        phaseCnt_reg <= 11'h000;
                    end else if (cycleTick) begin
                        phaseCnt_reg <= phaseCnt_reg - 11'h001;
                    end
                end
                default: begin
                    phase_reg <= cdc_timing_pkg::PH_IDLE;
                    phaseCnt_reg <= 11'h000;
                end
            endcase
        end
    end

    // warm-up measurements come first and give no result
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            measIdx_reg <= 4'h0;
            inSequence_reg <= 1'b0;
            resultValid <= 1'b0;
            sequenceDone <= 1'b0;
        end else begin
            resultValid <= measEnd && lastMeas;
            sequenceDone <= measEnd && lastMeas;
            if (measEnd) begin
                measIdx_reg <= lastMeas ? 4'h0 : measIdx_reg + 4'h1;
                inSequence_reg <= !lastMeas
                    && (trigMode == cdc_timing_pkg::TRIG_TIMER_STRETCHED);
            end
        end
    end

    assign prechargeActive = phase_reg[1];
    assign fullchargeActive = phase_reg[2];
    assign dischargeActive = phase_reg[3];

    // ********************************************************
    // guard and reference outputs
    // ********************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            guardCfg <= '0;
            gpPin3Out <= 1'b0;
            gpPin3OutEnN <= 1'b1;
        end else begin
            guardCfg.guardAmpSleep <= guardCtrl_reg[`GUARD_PULSED_BIT]
                && (phase_reg == cdc_timing_pkg::PH_IDLE) && !startMeas;
            guardCfg.guardAmpExternal <= guardCtrl_reg[`GUARD_EXTERNAL_BIT];
            guardCfg.guardEnable <= guardCtrl_reg[`GUARD_EN_MSB:0];
            guardCfg.refCapCode <= refcapHigh_reg[`REFCAP_MSB:`REFCAP_LSB];
            gpPin3OutEnN <= !guardCtrl_reg[`GUARD_EXTERNAL_BIT];
            gpPin3Out <= guardCtrl_reg[`GUARD_EXTERNAL_BIT]
                && (phase_reg != cdc_timing_pkg::PH_IDLE);
        end
    end

    // ********************************************************
    // checks
    // ********************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_fullEnd;
        fullchargeActive && phaseEnd;
    endsequence

    chk_phase_order: assert property (prechargeActive && phaseEnd |=> fullchargeActive)
        else $error("precharge not followed by full-charge");
    chk_full_to_discharge: assert property (s_fullEnd and disOn |=> dischargeActive)
        else $error("full-charge not followed by discharge");
    chk_discharge_skip: assert property (s_fullEnd and !disOn |=> !dischargeActive)
        else $error("disabled discharge was run");
    chk_full_load: assert property ($rose(fullchargeActive) |->
        phaseCnt_reg == {1'b0, fullchargeTime_reg} + (cycleSource_reg ? 11'h002 : 11'h001))
        else $error("full-charge length wrong");
    chk_pre_skip: assert property ($rose(prechargeActive) |-> $past(preOn))
        else $error("disabled precharge was run");
    chk_timer_period: assert property (timerFire && convPeriod_reg != 23'h000000 |=>
        timerCnt_reg == {convPeriod_reg, 1'b0} - 24'h000001)
        else $error("timer period reload wrong");
    chk_warmup_result: assert property (measEnd && !lastMeas |=> !resultValid)
        else $error("warm-up gave a result");
    chk_mux_pin: assert property (guardCtrl_reg[`GUARD_EXTERNAL_BIT] |=> !gpPin3OutEnN)
        else $error("guard mux pin not driven");
    chk_amp_sleep: assert property (!guardCtrl_reg[`GUARD_PULSED_BIT] |=> !guardCfg.guardAmpSleep)
        else $error("permanent guard amp slept");
endmodule // cdc_measurement_timing_config

// file: dv/test_cdc_measurement_timing_config.sv
// self-checking bench of the measurement timing block
// assumes the register port, oscillators and triggers are all driven from here
`timescale 1ns/1ps
module test_cdc_measurement_timing_config;
`include "cdc_timing_map.svh"
    typedef struct packed {logic [7:0] a, d, e;} reg_row_t;
    typedef struct packed {logic hf; logic [9:0] p, f, d; logic [10:0] ePre, eFull, eDis;} dur_row_t;
    typedef struct packed {logic [2:0] mode; logic [1:0] pin, drive; logic exp;} trig_row_t;
    // ************************************************************
    // signals and tables
    // ************************************************************
    localparam int CYCLE_LIMIT = 60000;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    cdc_timing_pkg::reg_req_t regReq = '0;
    logic [7:0] regRdData;
    logic lowFreqOsc = 1'b0;
    logic highFreqOsc = 1'b0;
    logic [3:0] gpPinIn = 4'h0;
    logic resultRead = 1'b0;
    logic commandStart = 1'b0;
    logic gpPin3Out, gpPin3OutEnN, prechargeActive, fullchargeActive, dischargeActive;
    logic resultValid, sequenceDone;
    cdc_timing_pkg::guard_cfg_t guardCfg;
    int errTotal = 0;
    int compares = 0;
    int cycles = 0;
    int rvCount = 0;
    int nPre, nFull, nDis, nMeas, tickIdx;
    int starts[$];
    logic [2:0] lastPh;
    // 0x0B bit7 is not stored; 0x20 lies outside the map
    reg_row_t regRows[12] = '{'{8'h09, 8'hA5, 8'hA5}, '{8'h0A, 8'h5A, 8'h5A}, '{8'h0B, 8'hFF, 8'h7F},
        '{8'h0C, 8'h3C, 8'h3C}, '{8'h0D, 8'hD9, 8'hD9}, '{8'h0E, 8'hC3, 8'hC3},
        '{8'h0F, 8'h3E, 8'h3E}, '{8'h10, 8'h96, 8'h96}, '{8'h11, 8'h55, 8'h55},
        '{8'h12, 8'h40, 8'h40}, '{8'h13, 8'h01, 8'h01}, '{8'h20, 8'hFF, 8'h00}};
    dur_row_t durRows[7] = '{'{1'b0, 10'h000, 10'h000, 10'h3FF, 11'h001, 11'h001, 11'h000},
        '{1'b0, 10'h002, 10'h003, 10'h001, 11'h003, 11'h004, 11'h002},
        '{1'b0, 10'h3FF, 10'h001, 10'h000, 11'h000, 11'h002, 11'h001},
        '{1'b0, 10'h001, 10'h3FF, 10'h3FF, 11'h002, 11'h400, 11'h000},
        '{1'b1, 10'h001, 10'h002, 10'h003, 11'h002, 11'h004, 11'h003},
        '{1'b1, 10'h001, 10'h3FF, 10'h3FF, 11'h003, 11'h401, 11'h000},
        '{1'b1, 10'h000, 10'h000, 10'h000, 11'h001, 11'h002, 11'h000}};
    trig_row_t trigRows[9] = '{'{3'h1, 2'h0, 2'h0, 1'b1}, '{3'h5, 2'h0, 2'h0, 1'b1},
        '{3'h5, 2'h1, 2'h1, 1'b1}, '{3'h5, 2'h2, 2'h2, 1'b1}, '{3'h5, 2'h3, 2'h3, 1'b1},
        '{3'h5, 2'h2, 2'h1, 1'b0}, '{3'h4, 2'h0, 2'h0, 1'b0}, '{3'h0, 2'h0, 2'h0, 1'b1},
        '{3'h7, 2'h0, 2'h0, 1'b1}};

    cdc_measurement_timing_config u_dut (.ref_clk(ref_clk), .rst(rst), .regReq(regReq),
        .regRdData(regRdData), .lowFreqOsc(lowFreqOsc), .highFreqOsc(highFreqOsc),
        .gpPinIn(gpPinIn), .resultRead(resultRead), .commandStart(commandStart),
        .gpPin3Out(gpPin3Out), .gpPin3OutEnN(gpPin3OutEnN), .prechargeActive(prechargeActive),
        .fullchargeActive(fullchargeActive), .dischargeActive(dischargeActive),
        .resultValid(resultValid), .sequenceDone(sequenceDone), .guardCfg(guardCfg));

    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errTotal++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finishTest();
        $display("errors %0d compares %0d", errTotal, compares);
        if (errTotal == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) regReq <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk) regReq <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk) regReq <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk) regReq <= '0;
        #1 chk(regRdData, e);
    endtask
    // oscillator ticks stay up and down long enough for the input filter
    task automatic tick(input logic hf);
        logic [2:0] ph;
        @(posedge ref_clk);
        if (hf) highFreqOsc <= 1'b1;
        else lowFreqOsc <= 1'b1;
        // sampled before this tick can close a phase, so each tick counts the phase it ends
        #1 ph = {prechargeActive, fullchargeActive, dischargeActive};
        nPre += ph[2];
        nFull += ph[1];
        nDis += ph[0];
        if (ph[1] && !lastPh[1]) begin
            nMeas++;
            starts.push_back(tickIdx);
        end
        lastPh = ph;
        tickIdx++;
        repeat (5) @(posedge ref_clk);
        lowFreqOsc <= 1'b0;
        highFreqOsc <= 1'b0;
        repeat (5) @(posedge ref_clk);
    endtask
    task automatic run(input logic hf, input int maxTicks, input logic stopOnRv);
        int rv0;
        rv0 = rvCount;
        {nPre, nFull, nDis, nMeas, tickIdx} = '0;
        lastPh = 3'b000;
        starts.delete();
        while (tickIdx < maxTicks && !(stopOnRv && rvCount != rv0)) tick(hf);
    endtask
    task automatic cfg(input logic hf, input logic [9:0] p, f, d, input logic [3:0] w,
        input logic [2:0] mode, input logic [1:0] pin);
        wr(8'h0E, p[7:0]);
        wr(8'h0F, {2'b00, w, p[9:8]});
        wr(8'h10, f[7:0]);
        wr(8'h11, {1'b0, 5'h15, f[9:8]});
        wr(8'h0C, d[7:0]);
        wr(8'h0D, {pin, 1'b0, mode, d[9:8]});
        wr(8'h13, {7'h00, hf});
    endtask
    task automatic pulseCmd();
        @(posedge ref_clk) commandStart <= 1'b1;
        @(posedge ref_clk) commandStart <= 1'b0;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (resultValid === 1'b1) rvCount++;
        if (!rst && sequenceDone !== resultValid) chk(sequenceDone, resultValid);
        if (cycles > CYCLE_LIMIT) begin
            errTotal++;
            finishTest();
        end
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (19) @(posedge ref_clk);
        #1 chk({gpPin3Out, gpPin3OutEnN, prechargeActive, fullchargeActive}, 4'h4);
        chk({dischargeActive, resultValid, sequenceDone, guardCfg, regRdData}, '0);
        @(posedge ref_clk) rst <= 1'b0;
        foreach (regRows[i]) begin
            rd(regRows[i].a, 8'h00);
            wr(regRows[i].a, regRows[i].d);
            rd(regRows[i].a, regRows[i].e);
        end
        cfg(1'b0, 10'h000, 10'h000, 10'h3FF, 4'h0, 3'h6, 2'h0);
        run(1'b0, 12, 1'b0);
        foreach (durRows[i]) begin
            cfg(durRows[i].hf, durRows[i].p, durRows[i].f, durRows[i].d, 4'h0, 3'h6, 2'h0);
            pulseCmd();
            run(durRows[i].hf, 1200, 1'b1);
            chk(nPre, durRows[i].ePre);
            chk(nFull, durRows[i].eFull);
            chk(nDis, durRows[i].eDis);
        end
        foreach (trigRows[i]) begin
            cfg(1'b0, 10'h000, 10'h000, 10'h3FF, 4'h0, trigRows[i].mode, trigRows[i].pin);
            @(posedge ref_clk);
            if (trigRows[i].mode == 3'h5) gpPinIn[trigRows[i].drive] <= 1'b1;
            else {resultRead, commandStart} <= {1'b1, trigRows[i].mode == 3'h4};
            repeat (5) @(posedge ref_clk);
            {gpPinIn, resultRead, commandStart} <= '0;
            repeat (8) @(posedge ref_clk);
            #1 chk(prechargeActive | fullchargeActive, trigRows[i].exp);
            wr(8'h0D, {trigRows[i].pin, 1'b0, 3'h6, 2'b11});
            run(1'b0, 10, 1'b0);
        end
        // mid-run reset: clears the long timer count left by the register table
        @(posedge ref_clk) rst <= 1'b1;
        @(posedge ref_clk) rst <= 1'b0;
        #1 chk({gpPin3OutEnN, prechargeActive, fullchargeActive, guardCfg, regRdData},
            24'h800000);
        // reset leaves continuous mode, so a measurement opens at once
        @(posedge ref_clk);
        #1 chk(prechargeActive, 1'b1);
        wr(8'h09, 8'h03);
        wr(8'h0A, 8'h00);
        wr(8'h0B, 8'h00);
        cfg(1'b0, 10'h000, 10'h000, 10'h3FF, 4'h0, 3'h2, 2'h0);
        run(1'b0, 20, 1'b0);
        // the first two gaps are cut short by the measurement that reset left open
        if (starts.size() < 4) chk(starts.size(), 4);
        else chk(starts[3] - starts[2], 6);
        wr(8'h0D, 8'h1B);
        run(1'b0, 10, 1'b0);
        // stretched: one timer fire runs two warm-ups and one counted measurement
        wr(8'h09, 8'h0A);
        cfg(1'b0, 10'h000, 10'h000, 10'h3FF, 4'h2, 3'h3, 2'h0);
        run(1'b0, 60, 1'b1);
        chk(nMeas, 3);
        cfg(1'b0, 10'h000, 10'h000, 10'h3FF, 4'h0, 3'h6, 2'h0);
        run(1'b0, 30, 1'b0);
        wr(8'h12, 8'hC5);
        repeat (2) @(posedge ref_clk);
        #1 chk(guardCfg, {1'b1, 1'b1, 6'h05, 5'h15});
        chk({gpPin3OutEnN, gpPin3Out}, 2'b00);
        pulseCmd();
        repeat (3) @(posedge ref_clk);
        #1 chk({gpPin3Out, guardCfg.guardAmpSleep}, 2'b10);
        run(1'b0, 10, 1'b1);
        wr(8'h12, 8'h3A);
        repeat (2) @(posedge ref_clk);
        #1 chk({gpPin3OutEnN, guardCfg}, {1'b1, 1'b0, 1'b0, 6'h3A, 5'h15});
        finishTest();
    end
endmodule // test_cdc_measurement_timing_config
